// ===== blink_divider.sv
// Blink phase divider: one-cycle toggle pulse every half blink period
`timescale 1ns/1ns
`default_nettype none

module blink_divider #(
  parameter int MS_CYCLES = led_indicator_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic       i_core_clk,
  input  wire logic       i_srst,
  // Rate select
  input  wire logic [1:0] i_rate,
  // Phase toggle pulse
  output logic            o_toggle
);

  localparam int CYC_W = $clog2(MS_CYCLES + 1);

  generate
    if (MS_CYCLES < 2) begin : g_bad_ms
      $error("MS_CYCLES must be at least 2");
    end
  endgenerate

  typedef struct packed {
    logic [CYC_W-1:0] cyc;
    logic [7:0]       ms;
    logic             tog;
  } div_state_t;

  div_state_t st;
  div_state_t next_st;
  logic       ms_tick;
  logic [7:0] half_ms;

  function automatic logic [7:0] half_period_ms(input logic [1:0] rate);
    case (rate)
      2'h0:    half_period_ms = 8'(led_indicator_pkg::BLINK_PERIOD_MS_20HZ / 2);
      2'h1:    half_period_ms = 8'(led_indicator_pkg::BLINK_PERIOD_MS_10HZ / 2);
      2'h2:    half_period_ms = 8'(led_indicator_pkg::BLINK_PERIOD_MS_5HZ / 2);
      default: half_period_ms = 8'(led_indicator_pkg::BLINK_PERIOD_MS_2HZ / 2);
    endcase
  endfunction

  always_comb begin
    next_st = st;
    half_ms = half_period_ms(i_rate);
    ms_tick = (st.cyc == CYC_W'(MS_CYCLES - 1));
    next_st.tog = 1'b0;
    if (ms_tick) begin
      next_st.cyc = '0;
      // A rate change can leave the count above the new limit, hence >=
      if (st.ms >= half_ms - 8'h01) begin // [R1]
        next_st.ms  = '0;
        next_st.tog = 1'b1;
      end else begin
        next_st.ms = st.ms + 8'h01;
      end
    end else begin
      next_st.cyc = st.cyc + CYC_W'(1);
    end
    if (i_srst) begin
      next_st = '0;
    end
  end

  always_ff @(posedge i_core_clk) begin
    st <= next_st;
  end

  assign o_toggle = st.tog;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_toggle_due : assert property (@(posedge i_core_clk) disable iff (i_srst) // [R1]
    (ms_tick && st.ms >= half_ms - 8'h01) |=> o_toggle)
    else $error("blink toggle missed at end of half period");
  a_toggle_cause : assert property (@(posedge i_core_clk) disable iff (i_srst) // [R1]
    o_toggle |-> $past(st.cyc) == CYC_W'(MS_CYCLES - 1))
    else $error("blink toggle outside a millisecond boundary");

endmodule // blink_divider

`default_nettype wire

// ===== indicator_lamps.sv
// Board lamp model: shows indicator levels and times lit runs of lamp two
`timescale 1ns/1ns
`default_nettype none

module indicator_lamps (
  // Clock
  input  wire logic       i_core_clk,
  // Indicator pins
  input  wire logic [2:0] i_pins,
  // Lamp state
  output logic      [2:0] o_lit,
  output int              o_run_len
);
  int run;

  assign o_lit = i_pins;

  initial begin
    run = 0;
    o_run_len = 0;
  end

  // Length in cycles of the last lit run of lamp two, kept for blink timing
  always @(posedge i_core_clk) begin
    if (i_pins[2]) begin
      run <= run + 1;
    end else if (run != 0) begin
      o_run_len <= run;
      run <= 0;
    end
  end
endmodule // indicator_lamps

`default_nettype wire

// ===== led_indicator_pkg.sv
// Constants and field layout shared by the indicator select block
package led_indicator_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_PS = 4000;
  localparam int PS_PER_MS     = 1000000000;
  localparam int MS_CYCLES     = PS_PER_MS / CLK_PERIOD_PS;

  localparam int BLINK_PERIOD_MS_20HZ = 50;
  localparam int BLINK_PERIOD_MS_10HZ = 100;
  localparam int BLINK_PERIOD_MS_5HZ  = 200;
  localparam int BLINK_PERIOD_MS_2HZ  = 500;

  // ----------------------------------------------------------------
  // Register map (byte addresses, low 12 bits decoded)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_SOURCE_CONFIG = 12'h460;
  localparam logic [11:0] ADDR_STATUS        = 12'h464;

  localparam int RATE_LSB = 12;
  localparam int SEL2_LSB = 8;
  localparam int SEL1_LSB = 4;
  localparam int SEL0_LSB = 0;

  localparam logic [15:0] SOURCE_CONFIG_RESET = 16'h2610;

  localparam int STAT_IND_LSB    = 0;
  localparam int STAT_LOSS_BIT   = 3;
  localparam int STAT_PERR_BIT   = 4;
  localparam int STAT_PHASE_BIT  = 5;

  // ----------------------------------------------------------------
  // Selector codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SEL_LINK        = 4'h0;
  localparam logic [3:0] SEL_LINK_RXTX   = 4'h1;
  localparam logic [3:0] SEL_LINK_TX_A   = 4'h2;
  localparam logic [3:0] SEL_LINK_TX_B   = 4'h3;
  localparam logic [3:0] SEL_LINK_LEADER = 4'h4;
  localparam logic [3:0] SEL_LINK_FOLLOW = 4'h5;
  localparam logic [3:0] SEL_ACTIVITY    = 4'h6;
  localparam logic [3:0] SEL_LINK_LOST   = 4'h9;
  localparam logic [3:0] SEL_PRBS_ERROR  = 4'hA;

  // ----------------------------------------------------------------
  // AHB-Lite encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] HSIZE_HALF    = 3'h1;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

endpackage

// ===== led_indicator_select.sv
// Indicator source select with blink, latched link loss and PRBS error
//
// Operation
// R1 - The 2-bit field at bits 13:12 picks a blink period of 50, 100, 200 or 500 ms.
// R2 - Indicator zero uses bits 3:0 (reset 0000); 0000 shows link, 0001 link with activity.
// R3 - Codes 0010 and 0011 show link with transmit activity, 0100 leader and 0101 follower.
// R4 - Code 0110 shows transmit or receive activity regardless of link.
// R5 - Code 1001 shows a latched link loss that only a read of register 0x1 clears.
// R6 - Code 1010 blinks on a latched test-pattern error until its counter is cleared.
// R7 - Software does not program the reserved codes; they show an unlit indicator.
// R8 - Indicator one uses bits 7:4 (reset 0001) with the same code table.
// R9 - Indicator two uses bits 11:8 (reset 0110) with the same code table.
// R10 - Activity and error sources blink at the set period; steady states drive the level.
`timescale 1ns/1ns
`default_nettype none

module led_indicator_select #(
  parameter int MS_CYCLES = led_indicator_pkg::MS_CYCLES
) (
  // Clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_srst,
  // AHB-Lite slave
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic      [31:0] o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // Link and activity sources
  input  wire logic        i_link_up,
  input  wire logic        i_rx_activity,
  input  wire logic        i_tx_activity,
  input  wire logic        i_leader_role,
  input  wire logic        i_prbs_error,
  input  wire logic        i_prbs_count_clear,
  input  wire logic        i_basic_status_read,
  // Indicator pins
  output logic             o_indicator_zero,
  output logic             o_indicator_one,
  output logic             o_indicator_two
);

  typedef struct packed {
    logic [15:0] cfg;
    logic        wr_cfg;
    logic [1:0]  wr_lanes;
    logic        link_prev;
    logic        link_loss;
    logic        prbs_err;
    logic        hold_rt;
    logic        hold_tx;
    logic        phase;
    logic [2:0]  ind;
    logic [31:0] hrdata;
    logic        hreadyout;
  } sel_state_t;

  sel_state_t  st;
  sel_state_t  next_st;
  logic        toggle;
  logic        act_rt;
  logic        act_tx;
  logic        addr_valid;
  logic [15:0] cfg_view;
  logic [1:0]  lanes;

  // ----------------------------------------------------------------
  // Source decode, shared by all three indicators
  // ----------------------------------------------------------------
  function automatic logic indicator_level(
    input logic [3:0] code,
    input logic       link,
    input logic       leader,
    input logic       rt,
    input logic       tx,
    input logic       loss,
    input logic       perr,
    input logic       phase
  );
    case (code)
      led_indicator_pkg::SEL_LINK:        indicator_level = link;                 // [R2]
      led_indicator_pkg::SEL_LINK_RXTX:   indicator_level = link & (!rt | phase); // [R2] [R10]
      led_indicator_pkg::SEL_LINK_TX_A,
      led_indicator_pkg::SEL_LINK_TX_B:   indicator_level = link & (!tx | phase); // [R3] [R10]
      led_indicator_pkg::SEL_LINK_LEADER: indicator_level = link & leader;        // [R3]
      led_indicator_pkg::SEL_LINK_FOLLOW: indicator_level = link & !leader;       // [R3]
      led_indicator_pkg::SEL_ACTIVITY:    indicator_level = rt & phase;           // [R4] [R10]
      led_indicator_pkg::SEL_LINK_LOST:   indicator_level = loss;                 // [R5]
      led_indicator_pkg::SEL_PRBS_ERROR:  indicator_level = perr & phase;         // [R6] [R10]
      default:                            indicator_level = 1'b0;                 // [R7]
    endcase
  endfunction

  function automatic logic [1:0] write_lanes(input logic [2:0] size, input logic [1:0] a);
    case (size)
      led_indicator_pkg::HSIZE_BYTE: write_lanes = {a == 2'h1, a == 2'h0};
      led_indicator_pkg::HSIZE_HALF: write_lanes = {2{a[1] == 1'b0}};
      default:                       write_lanes = 2'h3;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // Blink divider
  // ----------------------------------------------------------------
  blink_divider #(
    .MS_CYCLES (MS_CYCLES)
  ) u_blink_divider (
    .i_core_clk (i_core_clk),
    .i_srst     (i_srst),
    .i_rate     (st.cfg[led_indicator_pkg::RATE_LSB +: 2]), // [R1]
    .o_toggle   (toggle)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st    = st;
    act_rt     = st.hold_rt | i_rx_activity | i_tx_activity;
    act_tx     = st.hold_tx | i_tx_activity;
    addr_valid = i_hsel & i_hready & (i_htrans == led_indicator_pkg::HTRANS_NONSEQ);
    lanes      = write_lanes(i_hsize, i_haddr[1:0]);

    // Write data arrives in the data phase; forward it to a read behind it
    cfg_view = st.cfg;
    if (st.wr_cfg) begin
      if (st.wr_lanes[0]) cfg_view[7:0] = i_hwdata[7:0];
      if (st.wr_lanes[1]) cfg_view[15:8] = i_hwdata[15:8];
    end
    next_st.cfg = cfg_view;

    next_st.wr_cfg   = addr_valid & i_hwrite &
                       (i_haddr[11:0] == led_indicator_pkg::ADDR_SOURCE_CONFIG);
    next_st.wr_lanes = lanes;
    next_st.hrdata   = '0;
    if (addr_valid && !i_hwrite) begin
      case (i_haddr[11:0])
        led_indicator_pkg::ADDR_SOURCE_CONFIG: next_st.hrdata = {16'h0000, cfg_view};
        led_indicator_pkg::ADDR_STATUS: begin
          next_st.hrdata[led_indicator_pkg::STAT_IND_LSB +: 3] = st.ind;
          next_st.hrdata[led_indicator_pkg::STAT_LOSS_BIT]     = st.link_loss;
          next_st.hrdata[led_indicator_pkg::STAT_PERR_BIT]     = st.prbs_err;
          next_st.hrdata[led_indicator_pkg::STAT_PHASE_BIT]    = st.phase;
        end
        default: next_st.hrdata = '0;
      endcase
    end
    next_st.hreadyout = 1'b1;

    // Latches: a new event wins over a clear in the same cycle
    next_st.link_prev = i_link_up;
    next_st.link_loss = (st.link_prev & !i_link_up) |
                        (st.link_loss & !i_basic_status_read); // [R5]
    next_st.prbs_err  = i_prbs_error | (st.prbs_err & !i_prbs_count_clear); // [R6]

    // Activity is stretched to the next divider toggle so short bursts still reach the end of their blink phase
    if (toggle) begin
      next_st.phase   = !st.phase; // [R10]
      next_st.hold_rt = i_rx_activity | i_tx_activity;
      next_st.hold_tx = i_tx_activity;
    end else begin
      next_st.hold_rt = act_rt;
      next_st.hold_tx = act_tx;
    end

    next_st.ind[0] = indicator_level(st.cfg[led_indicator_pkg::SEL0_LSB +: 4], // [R2]
      i_link_up, i_leader_role, act_rt, act_tx, st.link_loss, st.prbs_err, st.phase);
    next_st.ind[1] = indicator_level(st.cfg[led_indicator_pkg::SEL1_LSB +: 4], // [R8]
      i_link_up, i_leader_role, act_rt, act_tx, st.link_loss, st.prbs_err, st.phase);
    next_st.ind[2] = indicator_level(st.cfg[led_indicator_pkg::SEL2_LSB +: 4], // [R9]
      i_link_up, i_leader_role, act_rt, act_tx, st.link_loss, st.prbs_err, st.phase);

    if (i_srst) begin
      next_st           = '0;
      next_st.cfg       = led_indicator_pkg::SOURCE_CONFIG_RESET; // [R2] [R8] [R9]
      next_st.hreadyout = 1'b1;
    end
  end

  always_ff @(posedge i_core_clk) begin
    st <= next_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_hrdata         = st.hrdata;
  assign o_hreadyout      = st.hreadyout;
  assign o_hresp          = led_indicator_pkg::HRESP_OKAY;
  assign o_indicator_zero = st.ind[0];
  assign o_indicator_one  = st.ind[1];
  assign o_indicator_two  = st.ind[2];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);

  a_zero_link_only : assert property ( // [R2]
    st.cfg[3:0] == led_indicator_pkg::SEL_LINK |=> o_indicator_zero == $past(i_link_up))
    else $error("indicator zero does not follow link");
  a_zero_link_act : assert property ( // [R2]
    (st.cfg[3:0] == led_indicator_pkg::SEL_LINK_RXTX) && !i_link_up |=> !o_indicator_zero)
    else $error("indicator zero lit without link");
  a_zero_roles : assert property ( // [R3]
    st.cfg[3:0] == led_indicator_pkg::SEL_LINK_FOLLOW
      |=> o_indicator_zero == $past(i_link_up && !i_leader_role))
    else $error("follower indication wrong");
  a_zero_act_only : assert property ( // [R4]
    (st.cfg[3:0] == led_indicator_pkg::SEL_ACTIVITY) && i_tx_activity && st.phase
      && !i_link_up |=> o_indicator_zero)
    else $error("activity indication depends on link");
  a_loss_sticky : assert property ( // [R5]
    st.link_loss && !i_basic_status_read |=> st.link_loss [*1] ##1 1'b1)
    else $error("link loss cleared without status read");
  a_prbs_sticky : assert property ( // [R6]
    $rose(st.prbs_err) && !i_prbs_count_clear |=> st.prbs_err)
    else $error("test-pattern error latch dropped");
  a_one_reset_code : assert property ( // [R8]
    $past(i_srst) |-> st.cfg == led_indicator_pkg::SOURCE_CONFIG_RESET)
    else $error("configuration reset value wrong");
  a_one_link : assert property ( // [R8]
    st.cfg[7:4] == led_indicator_pkg::SEL_LINK |=> o_indicator_one == $past(i_link_up))
    else $error("indicator one does not follow link");
  a_two_link : assert property ( // [R9]
    st.cfg[11:8] == led_indicator_pkg::SEL_LINK |=> o_indicator_two == $past(i_link_up))
    else $error("indicator two does not follow link");
  a_phase_step : assert property ( // [R10]
    $changed(st.phase) && !$past(i_srst) |-> $past(toggle))
    else $error("blink phase changed without divider toggle");

  c_loss_seen : cover property ($rose(st.link_loss));
  c_prbs_seen : cover property ($rose(st.prbs_err));
  c_cfg_write : cover property (st.wr_cfg);
  c_blink     : cover property (toggle ##1 o_indicator_two);

endmodule // led_indicator_select

`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the indicator select block
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // ----------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------
  // Short ms keeps the 500 ms blink near a thousand cycles per half
  localparam int MS = 4;
  localparam int HALF_MS [4] = '{25, 50, 100, 250};
  logic        i_core_clk;
  logic        i_srst;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hready;
  logic [6:0]  src;
  wire [2:0]   pins;
  logic        hresp;
  logic [2:0]  lit;
  int          run_len;
  int          num_errors;
  int          total_checks;
  logic [31:0] exp_q [$];
  logic        rd_dp = 1'b0;
  logic [31:0] v;
  int          h;

  led_indicator_select #(.MS_CYCLES(MS)) u_dut (
    .i_core_clk(i_core_clk), .i_srst(i_srst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(led_indicator_pkg::HSIZE_WORD),
    .i_hwdata(hwdata), .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready),
    .o_hresp(hresp), .i_link_up(src[0]), .i_rx_activity(src[1]), .i_tx_activity(src[2]),
    .i_leader_role(src[3]), .i_prbs_error(src[4]), .i_prbs_count_clear(src[5]),
    .i_basic_status_read(src[6]), .o_indicator_zero(pins[0]),
    .o_indicator_one(pins[1]), .o_indicator_two(pins[2]));

  indicator_lamps u_lamps (.i_core_clk(i_core_clk), .i_pins(pins), .o_lit(lit),
    .o_run_len(run_len));

  initial begin
    i_core_clk = 1'b0;
    forever #2 i_core_clk = ~i_core_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge i_core_clk);
    hsel   <= 1'b1;
    htrans <= led_indicator_pkg::HTRANS_NONSEQ;
    haddr  <= {20'h0, a};
    hwrite <= w;
    do @(posedge i_core_clk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge i_core_clk); while (hready !== 1'b1);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, $urandom);
  endtask

  task automatic cfg(input logic [1:0] r, input logic [3:0] c);
    bus(1'b1, 12'h460, {16'h0, 2'b00, r, c, c, c});
  endtask

  task automatic drive(input logic [6:0] s);
    @(posedge i_core_clk);
    src <= s;
  endtask

  // Lamps must show want for n cycles after skip cycles of settling
  task automatic hold(input logic [2:0] want, input int skip, input int n);
    logic [2:0] bad;
    bad = 3'h0;
    repeat (skip) @(posedge i_core_clk);
    repeat (n) begin
      @(posedge i_core_clk);
      #1;
      bad = bad | (lit ^ want);
    end
    check({29'h0, bad}, 32'h0);
  endtask

  task automatic wait_two(input logic want, input int limit);
    for (int i = 0; i < limit && lit[2] !== want; i++) begin
      @(posedge i_core_clk);
      #1;
    end
    check({31'h0, lit[2]}, {31'h0, want});
  endtask

  function automatic logic [3:0] pick();
    logic [3:0] t [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h9, 4'hA};
    return t[$urandom_range(8)];
  endfunction

  // Read data is taken at the edge ending each read data phase
  always @(posedge i_core_clk) begin
    if (rd_dp && hready === 1'b1) begin
      check(hrdata, exp_q.pop_front());
      check({31'h0, hresp}, {31'h0, led_indicator_pkg::HRESP_OKAY});
    end
    if (hready === 1'b1) begin
      rd_dp <= hsel && htrans == led_indicator_pkg::HTRANS_NONSEQ && !hwrite;
    end
  end

  initial begin
    #(4 * 40000);
    num_errors++;
    results();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    i_srst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    src = 7'h00;
    num_errors = 0;
    total_checks = 0;
    void'($urandom(34706));
    repeat (3) @(posedge i_core_clk);
    i_srst <= 1'b0;
    rd(12'h460, 32'h0000_2610);
    rd(12'h100, 32'h0);
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      v[11:0] = {pick(), pick(), pick()};
      bus(1'b1, 12'h460, v);
      rd(12'h460, {16'h0, v[15:0]});
    end
    for (int c = 0; c < 6; c++) begin
      cfg(2'h0, c[3:0]);
      for (int k = 0; k < 4; k++) begin
        drive({3'h0, k[1], 2'h0, k[0]});
        v[0] = k[0] && (c == 4 ? k[1] : (c == 5 ? !k[1] : 1'b1));
        hold({3{v[0]}}, 1, 2);
      end
    end
    for (int r = 0; r < 4; r++) begin
      h = HALF_MS[r] * MS;
      // Alternate rx and tx so transmit-only activity without link is seen too
      drive(r[0] ? 7'h04 : 7'h02);
      cfg(r[1:0], 4'h6);
      wait_two(1'b1, 2 * h + 8);
      wait_two(1'b0, h + 8);
      wait_two(1'b1, h + 8);
      wait_two(1'b0, h + 8);
      // The lamp records a run one edge after it ends; the first run may be cut short
      @(posedge i_core_clk);
      #1;
      check(run_len, h);
    end
    drive(7'h01);
    cfg(2'h0, 4'h9);
    drive(7'h41);
    drive(7'h01);
    hold(3'h0, 2, 3);
    drive(7'h00);
    hold(3'h7, 2, 3);
    drive(7'h01);
    hold(3'h7, 2, 5);
    drive(7'h41);
    drive(7'h01);
    hold(3'h0, 2, 3);
    h = HALF_MS[0] * MS;
    cfg(2'h0, 4'hA);
    drive(7'h21);
    drive(7'h01);
    hold(3'h0, 2, 2 * h + 8);
    drive(7'h11);
    drive(7'h01);
    wait_two(1'b1, 2 * h + 8);
    wait_two(1'b0, h + 8);
    wait_two(1'b1, h + 8);
    drive(7'h21);
    drive(7'h01);
    hold(3'h0, 2, 2 * h + 8);
    results();
  end
endmodule // tb_top

`default_nettype wire
